// ===== core/tpc_pkg.sv
// shared constants and types of the timer prescaler and capture block
package tpc_pkg;

	localparam int TPC_ADDR_W = 8;
	localparam int TPC_DATA_W = 32;
	localparam int TPC_CAP_W = 16;
	localparam int TPC_PRESC_W = 4;
	localparam int TPC_DIV_CNT_W = 5;
	localparam int TPC_SHIFT_W = 3;

	// register byte offsets
	localparam logic [TPC_ADDR_W-1:0] TPC_OFS_RUN = 8'h00;
	localparam logic [TPC_ADDR_W-1:0] TPC_OFS_CGCFG = 8'h04;
	localparam logic [TPC_ADDR_W-1:0] TPC_OFS_CAP0 = 8'h08;
	localparam logic [TPC_ADDR_W-1:0] TPC_OFS_CAP1 = 8'h0C;
	localparam logic [TPC_ADDR_W-1:0] TPC_OFS_PSTAT = 8'h10;

	// field positions
	localparam int TPC_RUN_BIT = 0;
	localparam int TPC_PRCK_LSB = 0;
	localparam int TPC_GEAR_LSB = 4;
	localparam int TPC_FPSEL_BIT = 8;
	localparam int TPC_PHASE_BIT = 4;

	// reset values
	localparam logic TPC_RUN_RST = 1'b0;
	localparam logic [2:0] TPC_PRCK_RST = 3'h0;
	localparam logic [2:0] TPC_GEAR_RST = 3'h0;
	localparam logic TPC_FPSEL_RST = 1'b0;
	localparam logic [TPC_CAP_W-1:0] TPC_CAP_RST = 16'h0000;

	// clock gear codes
	localparam logic [2:0] TPC_GEAR_FC = 3'h0;
	localparam logic [2:0] TPC_GEAR_FC2 = 3'h4;
	localparam logic [2:0] TPC_GEAR_FC4 = 3'h5;
	localparam logic [2:0] TPC_GEAR_FC8 = 3'h6;

	// prescaler clock select: largest legal code (fperiph/32)
	localparam logic [2:0] TPC_PRCK_MAX = 3'h5;

	// prescaler tap bits (divide by 2 and by 8) and the full count
	localparam int TPC_TAP1_BIT = 0;
	localparam int TPC_TAP4_BIT = 2;
	localparam logic [TPC_PRESC_W-1:0] TPC_PRESC_FULL = 4'hF;
	localparam logic [TPC_PRESC_W-1:0] TPC_PRESC_ONE = 4'h1;
	localparam logic [TPC_PRESC_W-1:0] TPC_PRESC_ZERO = 4'h0;

	localparam logic [1:0] TPC_RESP_OKAY = 2'h0;
	localparam logic [1:0] TPC_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic tap_div2;
		logic tap_div8;
		logic tap_div32;
	} tpc_ticks_type;

endpackage

// ===== core/tpc_rate_div.sv
// power-of-two clock-enable divider
`timescale 1ns/1ps
module tpc_rate_div
	import tpc_pkg::*;
#(
	parameter int CNT_W = TPC_DIV_CNT_W,
	parameter int SHIFT_W = TPC_SHIFT_W
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // sync reset, active low
	input wire logic clr, // hold count at zero
	input wire logic en_in, // input rate enable
	input wire logic [SHIFT_W-1:0] shift, // divide by two to this power
	output logic en_out // output rate enable
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} tpc_div_state_type;

	tpc_div_state_type st_r;
	tpc_div_state_type st_nxt;
	logic [CNT_W-1:0] mask;

	always_comb begin
		st_nxt = st_r;
		mask = ~({CNT_W{1'b1}} << shift);
		en_out = en_in & ((st_r.cnt & mask) == mask);
		if (clr) begin
			st_nxt.cnt = '0;
			en_out = 1'b0;
		end else if (en_in) begin
			st_nxt.cnt = st_r.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r.cnt <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule

// ===== core/tpc_capture.sv
// one capture holding register for the up-counter value
`timescale 1ns/1ps
module tpc_capture
	import tpc_pkg::*;
#(
	parameter int W = TPC_CAP_W
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // sync reset, active low
	input wire logic capture_stb, // latch the count this cycle
	input wire logic [W-1:0] count_in, // live up-counter value
	output logic [W-1:0] value // last latched value
);

	typedef struct packed {
		logic [W-1:0] value;
	} tpc_cap_state_type;

	tpc_cap_state_type st_r;
	tpc_cap_state_type st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (capture_stb) begin
			st_nxt.value = count_in;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r.value <= W'(TPC_CAP_RST);
		end else begin
			st_r <= st_nxt;
		end
	end

	assign value = st_r.value;

endmodule

// ===== core/tpc_top.sv
// timer prescaler and capture read-out with an AXI4-Lite register slave
`timescale 1ns/1ps
module tpc_top
	import tpc_pkg::*;
#(
	parameter int CAP_W = TPC_CAP_W,
	parameter int PRESC_W = TPC_PRESC_W
) (
	input wire logic aclk, // system clock, 20 MHz
	input wire logic aresetn, // sync reset, active low
	input wire logic [TPC_ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [TPC_DATA_W-1:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [TPC_ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [TPC_DATA_W-1:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [CAP_W-1:0] up_counter, // live up-counter value
	input wire logic capture_stb_zero, // latch into capture zero
	input wire logic capture_stb_one, // latch into capture one
	output tpc_ticks_type ticks, // prescaler tap enables
	output logic prescaler_running // prescaler run state
);

	typedef struct packed {
		logic aw_ready;
		logic w_ready;
		logic have_aw;
		logic have_w;
		logic [TPC_ADDR_W-1:0] aw_addr;
		logic [TPC_DATA_W-1:0] w_data;
		logic [3:0] w_strb;
		logic b_valid;
		logic [1:0] b_resp;
		logic ar_ready;
		logic r_valid;
		logic [TPC_DATA_W-1:0] r_data;
		logic [1:0] r_resp;
		logic prescaler_run_bit;
		logic [2:0] prck;
		logic [2:0] gear;
		logic fpsel;
		logic [PRESC_W-1:0] presc;
		logic phase;
		tpc_ticks_type ticks;
	} tpc_state_type;

	tpc_state_type st_r;
	tpc_state_type st_nxt;

	// reset image: bus idle and ready, prescaler stopped and cleared
	localparam tpc_state_type ST_RST = '{
		aw_ready: 1'b1,
		w_ready: 1'b1,
		have_aw: 1'b0,
		have_w: 1'b0,
		aw_addr: '0,
		w_data: '0,
		w_strb: '0,
		b_valid: 1'b0,
		b_resp: TPC_RESP_OKAY,
		ar_ready: 1'b1,
		r_valid: 1'b0,
		r_data: '0,
		r_resp: TPC_RESP_OKAY,
		prescaler_run_bit: TPC_RUN_RST,
		prck: TPC_PRCK_RST,
		gear: TPC_GEAR_RST,
		fpsel: TPC_FPSEL_RST,
		presc: '0,
		phase: 1'b0,
		ticks: '0
	};

	// byte lane of the write strobe that guards each field
	localparam int RUN_LANE = TPC_RUN_BIT / 8;
	localparam int SEL_LANE = TPC_PRCK_LSB / 8;
	localparam int FPSEL_LANE = TPC_FPSEL_BIT / 8;

	logic [CAP_W-1:0] captured_count_zero;
	logic [CAP_W-1:0] captured_count_one;
	logic [TPC_SHIFT_W-1:0] gear_shift;
	logic [TPC_SHIFT_W-1:0] prck_shift;
	logic gear_tick;
	logic periph_tick;
	logic t0_tick;
	logic [PRESC_W-1:0] presc_inc;
	logic [TPC_DATA_W-1:0] rd_word;
	logic rd_hit;
	logic aw_take;
	logic w_take;
	logic b_take;
	logic ar_take;
	logic r_take;

	// gear code to divide exponent; unlisted codes run undivided
	always_comb begin
		case (st_r.gear)
			TPC_GEAR_FC: gear_shift = 3'h0;
			TPC_GEAR_FC2: gear_shift = 3'h1;
			TPC_GEAR_FC4: gear_shift = 3'h2;
			TPC_GEAR_FC8: gear_shift = 3'h3;
			default: gear_shift = 3'h0;
		endcase
	end

	// reserved prescaler clock codes fall back to fperiph/1
	always_comb begin
		if (st_r.prck > TPC_PRCK_MAX) begin
			prck_shift = 3'h0;
		end else begin
			prck_shift = st_r.prck;
		end
	end

	tpc_rate_div u_gear_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.clr(1'b0),
		.en_in(1'b1),
		.shift(gear_shift),
		.en_out(gear_tick)
	);

	// fsel one picks the oscillator ahead of the gear
	assign periph_tick = st_r.fpsel ? 1'b1 : gear_tick;

	tpc_rate_div u_presc_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.clr(~st_r.prescaler_run_bit),
		.en_in(periph_tick),
		.shift(prck_shift),
		.en_out(t0_tick)
	);

	// identical capture slice per register
	tpc_capture u_cap_zero (
		.aclk(aclk),
		.aresetn(aresetn),
		.capture_stb(capture_stb_zero),
		.count_in(up_counter),
		.value(captured_count_zero)
	);

	tpc_capture u_cap_one (
		.aclk(aclk),
		.aresetn(aresetn),
		.capture_stb(capture_stb_one),
		.count_in(up_counter),
		.value(captured_count_one)
	);

	assign presc_inc = st_r.presc + TPC_PRESC_ONE;

	// one item moves on a channel when its valid and ready meet
	assign aw_take = s_axi_awvalid & st_r.aw_ready;
	assign w_take = s_axi_wvalid & st_r.w_ready;
	assign b_take = st_r.b_valid & s_axi_bready;
	assign ar_take = s_axi_arvalid & st_r.ar_ready;
	assign r_take = st_r.r_valid & s_axi_rready;

	// read decode: the five register offsets only, others answer SLVERR
	always_comb begin
		rd_word = '0;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			TPC_OFS_RUN: begin
				rd_word[TPC_RUN_BIT] = st_r.prescaler_run_bit;
			end
			TPC_OFS_CGCFG: begin
				rd_word[TPC_PRCK_LSB +: 3] = st_r.prck;
				rd_word[TPC_GEAR_LSB +: 3] = st_r.gear;
				rd_word[TPC_FPSEL_BIT] = st_r.fpsel;
			end
			TPC_OFS_CAP0: begin
				rd_word[CAP_W-1:0] = captured_count_zero;
			end
			TPC_OFS_CAP1: begin
				rd_word[CAP_W-1:0] = captured_count_one;
			end
			TPC_OFS_PSTAT: begin
				rd_word[PRESC_W-1:0] = st_r.presc;
				rd_word[TPC_PHASE_BIT] = st_r.phase;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	always_comb begin
		st_nxt = st_r;

		// write channel: address and data taken in either order
		if (aw_take) begin
			st_nxt.aw_ready = 1'b0;
			st_nxt.have_aw = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr;
		end
		if (w_take) begin
			st_nxt.w_ready = 1'b0;
			st_nxt.have_w = 1'b1;
			st_nxt.w_data = s_axi_wdata;
			st_nxt.w_strb = s_axi_wstrb;
		end
		if (st_r.have_aw && st_r.have_w && !st_r.b_valid) begin
			st_nxt.have_aw = 1'b0;
			st_nxt.have_w = 1'b0;
			st_nxt.b_valid = 1'b1;
			st_nxt.b_resp = TPC_RESP_OKAY;
			case (st_r.aw_addr)
				TPC_OFS_RUN: begin
					if (st_r.w_strb[RUN_LANE]) begin
						st_nxt.prescaler_run_bit =
							st_r.w_data[TPC_RUN_BIT];
					end
				end
				TPC_OFS_CGCFG: begin
					if (st_r.w_strb[SEL_LANE]) begin
						st_nxt.prck = st_r.w_data[TPC_PRCK_LSB +: 3];
						st_nxt.gear = st_r.w_data[TPC_GEAR_LSB +: 3];
					end
					if (st_r.w_strb[FPSEL_LANE]) begin
						st_nxt.fpsel = st_r.w_data[TPC_FPSEL_BIT];
					end
				end
				// read-only words ignore writes
				TPC_OFS_CAP0, TPC_OFS_CAP1, TPC_OFS_PSTAT: begin
					st_nxt.b_resp = TPC_RESP_OKAY;
				end
				default: begin
					st_nxt.b_resp = TPC_RESP_SLVERR;
				end
			endcase
		end
		if (b_take) begin
			st_nxt.b_valid = 1'b0;
			st_nxt.aw_ready = 1'b1;
			st_nxt.w_ready = 1'b1;
		end

		// read channel: data answered one cycle after the address
		if (ar_take) begin
			st_nxt.ar_ready = 1'b0;
			st_nxt.r_valid = 1'b1;
			st_nxt.r_data = rd_word;
			st_nxt.r_resp = rd_hit ? TPC_RESP_OKAY : TPC_RESP_SLVERR;
		end
		if (r_take) begin
			st_nxt.r_valid = 1'b0;
			st_nxt.ar_ready = 1'b1;
		end

		// prescaler and its taps, one-cycle enables
		st_nxt.ticks = '0;
		if (!st_r.prescaler_run_bit) begin
			st_nxt.presc = TPC_PRESC_ZERO;
			st_nxt.phase = 1'b0;
		end else if (t0_tick) begin
			st_nxt.presc = presc_inc;
			st_nxt.ticks.tap_div2 = presc_inc[TPC_TAP1_BIT]
				& ~st_r.presc[TPC_TAP1_BIT];
			st_nxt.ticks.tap_div8 = presc_inc[TPC_TAP4_BIT]
				& ~st_r.presc[TPC_TAP4_BIT];
			if (st_r.presc == TPC_PRESC_FULL) begin
				// every second wrap of the count gives divide by 32
				st_nxt.phase = ~st_r.phase;
				st_nxt.ticks.tap_div32 = st_r.phase;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign s_axi_awready = st_r.aw_ready;
	assign s_axi_wready = st_r.w_ready;
	assign s_axi_bvalid = st_r.b_valid;
	assign s_axi_bresp = st_r.b_resp;
	assign s_axi_arready = st_r.ar_ready;
	assign s_axi_rvalid = st_r.r_valid;
	assign s_axi_rdata = st_r.r_data;
	assign s_axi_rresp = st_r.r_resp;
	assign ticks = st_r.ticks;
	assign prescaler_running = st_r.prescaler_run_bit;

endmodule

// ===== testbench/tpc_properties.sv
// concurrent checks on the prescaler and capture block ports
`timescale 1ns/1ps
module tpc_properties
	import tpc_pkg::*;
(
	input wire logic aclk, // clock
	input wire logic aresetn, // reset
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_bready, // b ready
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic [TPC_DATA_W-1:0] s_axi_rdata, // read data
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready, // r ready
	input wire tpc_ticks_type ticks, // taps
	input wire logic prescaler_running // run state
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_write_latency: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid |-> ##2 s_axi_bvalid) else $error("late b");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid) else $error("b dropped");
	a_read_latency: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("late r");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r moved");
	a_stop_quiet: assert property (
		!prescaler_running [*3] |-> ticks == 3'h0) else $error("tick");
	a_div2_single: assert property (
		ticks.tap_div2 |=> !ticks.tap_div2) else $error("div2 wide");
	a_div8_single: assert property (
		ticks.tap_div8 |=> !ticks.tap_div8) else $error("div8 wide");
	a_div32_single: assert property (
		ticks.tap_div32 |=> !ticks.tap_div32) else $error("div32 wide");
	c_div32: cover property (ticks.tap_div32);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

// ===== testbench/tpc_top_test.sv
// self-checking bench for the timer prescaler and capture block
`timescale 1ns/1ps
module tpc_top_test;
	import tpc_pkg::*;
	logic aclk, aresetn, awv, wv, bry, arv, rry, stb0, stb1;
	logic awr, wrd, bv, arr, rv, run;
	logic [1:0] br, rr;
	logic [7:0] awa, ara;
	logic [31:0] wd, rdat;
	logic [15:0] uc;
	tpc_ticks_type tk;
	int miscompares, check_count;
	tpc_top tpc_top_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rry), .up_counter(uc),
		.capture_stb_zero(stb0), .capture_stb_one(stb1), .ticks(tk),
		.prescaler_running(run));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wchk(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
		end while (bv !== 1'b1);
		bry <= 1'b0;
		chk({30'h0, br}, {30'h0, e});
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do begin
			@(posedge aclk);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		rry <= 1'b0;
		chk(rdat, e);
		chk({30'h0, rr}, {30'h0, er});
	endtask
	// skips two pulses so a rate change has settled, then measures
	task automatic period(input int b, output logic [31:0] p);
		for (int k = 0; k < 2; k++) begin
			do @(posedge aclk); while (tk[b] !== 1'b1);
		end
		p = 0;
		do begin
			@(posedge aclk);
			p++;
		end while (tk[b] !== 1'b1 && p < 5000);
	endtask
	task automatic t_regs();
		rchk(TPC_OFS_RUN, 32'h0, TPC_RESP_OKAY);
		rchk(TPC_OFS_CGCFG, 32'h0, TPC_RESP_OKAY);
		rchk(TPC_OFS_CAP0, 32'h0, TPC_RESP_OKAY);
		rchk(TPC_OFS_CAP1, 32'h0, TPC_RESP_OKAY);
		rchk(8'h14, 32'h0, TPC_RESP_SLVERR);
		wchk(8'h02, 32'h1, TPC_RESP_SLVERR);
		$display("registers test done");
	endtask
	task automatic t_capture();
		@(posedge aclk);
		uc <= 16'hA5C3;
		stb0 <= 1'b1;
		@(posedge aclk);
		uc <= 16'h5A3C;
		stb0 <= 1'b0;
		stb1 <= 1'b1;
		@(posedge aclk);
		uc <= 16'hFFFF;
		stb1 <= 1'b0;
		rchk(TPC_OFS_CAP0, 32'h0000A5C3, TPC_RESP_OKAY);
		rchk(TPC_OFS_CAP1, 32'h00005A3C, TPC_RESP_OKAY);
		wchk(TPC_OFS_CAP0, 32'hFFFFFFFF, TPC_RESP_OKAY);
		rchk(TPC_OFS_CAP0, 32'h0000A5C3, TPC_RESP_OKAY);
		$display("capture test done");
	endtask
	task automatic t_rates();
		logic [31:0] p;
		logic [2:0] gear [4] = '{3'h0, 3'h4, 3'h5, 3'h6};
		wchk(TPC_OFS_RUN, 32'h1, TPC_RESP_OKAY);
		for (int s = 0; s < 6; s++) begin
			wchk(TPC_OFS_CGCFG, 32'h100 | s, TPC_RESP_OKAY);
			period(2, p);
			chk(p, 32'h2 << s);
		end
		wchk(TPC_OFS_CGCFG, 32'h100, TPC_RESP_OKAY);
		period(1, p);
		chk(p, 32'h8);
		period(0, p);
		chk(p, 32'h20);
		for (int g = 0; g < 4; g++) begin
			wchk(TPC_OFS_CGCFG, {25'h0, gear[g], 4'h0}, TPC_RESP_OKAY);
			period(2, p);
			chk(p, 32'h2 << g);
		end
		// reserved select and gear codes run undivided
		wchk(TPC_OFS_CGCFG, 32'h106, TPC_RESP_OKAY);
		period(2, p);
		chk(p, 32'h2);
		wchk(TPC_OFS_CGCFG, 32'h10, TPC_RESP_OKAY);
		period(2, p);
		chk(p, 32'h2);
		$display("rates test done");
	endtask
	task automatic t_stop();
		logic [31:0] n;
		wchk(TPC_OFS_RUN, 32'h0, TPC_RESP_OKAY);
		repeat (4) @(posedge aclk);
		n = 0;
		repeat (80) begin
			@(posedge aclk);
			if (tk !== 3'h0) n++;
		end
		chk(n, 32'h0);
		chk({31'h0, run}, 32'h0);
		rchk(TPC_OFS_PSTAT, 32'h0, TPC_RESP_OKAY);
		$display("stop test done");
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	initial begin
		#500000;
		miscompares++;
		conclude();
	end
	initial begin
		{aresetn, awv, wv, bry, arv, rry, stb0, stb1} = 8'h00;
		awa = 8'h00;
		ara = 8'h00;
		wd = 32'h0;
		uc = 16'h0000;
		miscompares = 0;
		check_count = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_capture();
		t_rates();
		t_stop();
		conclude();
	end
endmodule
bind tpc_top tpc_properties tpc_properties_i (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .ticks(ticks),
	.prescaler_running(prescaler_running));
